// [design/uvp_pkg.sv]
package uvp_pkg;
  localparam int unsigned CLK_HZ        = 25000000;
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned ADDR_W        = 11;
  localparam int unsigned DATA_W        = 8;
  // Read timing (ns)
  localparam int unsigned ADDRESS_TO_DATA_DELAY_NS = 450;
  localparam int unsigned GATE_TO_DATA_DELAY_NS    = 120;
  // Program timing
  localparam int unsigned SETUP_US                 = 2;
  localparam int unsigned HOLD_US                  = 2;
  localparam int unsigned PROGRAM_PULSE_WIDTH_MS   = 50;
  localparam int unsigned PROGRAM_PULSE_MIN_MS     = 45;
  localparam int unsigned PROGRAM_PULSE_MAX_MS     = 55;
  localparam int unsigned FLOAT_NS                 = 120;
  // Least times round up
  localparam int unsigned ACC_CYC   =
    (ADDRESS_TO_DATA_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned OE_CYC    = (GATE_TO_DATA_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SETUP_CYC = (SETUP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned HOLD_CYC  = (HOLD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned FLOAT_CYC = (FLOAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PULSE_CYC = (PROGRAM_PULSE_WIDTH_MS * 1000) / CLK_PERIOD_NS * 1000;
  localparam int unsigned CNT_W     = 24;
  typedef enum logic [2:0] {
    UVP_IDLE, UVP_RD_SETUP, UVP_RD_WAIT, UVP_PG_SETUP, UVP_PG_PULSE, UVP_PG_HOLD,
    UVP_FLOAT
  } uvp_state_e;
endpackage : uvp_pkg

// [design/uvp_host.sv]
`timescale 1ns/1ns
module uvp_host
  import uvp_pkg::*;
#(
  parameter int unsigned NUM_DEV   = 1,
  parameter int unsigned PULSE_LEN = uvp_pkg::PULSE_CYC
)
(
  input  wire logic                       core_clk,
  input  wire logic                       sys_rst,
  input  wire logic                       req_valid,
  input  wire logic                       req_write,
  input  wire logic                       req_pgm_mode,
  input  wire logic [NUM_DEV-1:0]         req_dev_sel,
  input  wire logic [uvp_pkg::ADDR_W-1:0] req_addr,
  input  wire logic [uvp_pkg::DATA_W-1:0] req_wdata,
  output logic                            req_ready,
  output logic                            rsp_valid,
  output logic [uvp_pkg::DATA_W-1:0]      rsp_rdata,
  output logic [uvp_pkg::ADDR_W-1:0]      mem_addr,
  output logic [NUM_DEV-1:0]              mem_ce,
  output logic [NUM_DEV-1:0]              mem_oe_n,
  output logic                            mem_vpp_high,
  output logic [uvp_pkg::DATA_W-1:0]      mem_data_out,
  output logic                            mem_data_oe,
  input  wire logic [uvp_pkg::DATA_W-1:0] mem_data_in
);
  import uvp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser: data pins are asynchronous to core_clk
  logic [DATA_W-1:0] din_meta;
  logic [DATA_W-1:0] din_sync;

  always_ff @(posedge core_clk)
  begin
    din_meta <= mem_data_in;
    din_sync <= din_meta;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  uvp_state_e          state;
  uvp_state_e          next_state;
  logic [CNT_W-1:0]    cnt;
  logic [CNT_W-1:0]    next_cnt;
  logic                next_req_ready;
  logic                next_rsp_valid;
  logic [DATA_W-1:0]   next_rsp_rdata;
  logic [ADDR_W-1:0]   next_mem_addr;
  logic [NUM_DEV-1:0]  next_mem_ce;
  logic [NUM_DEV-1:0]  next_mem_oe_n;
  logic                next_mem_vpp_high;
  logic [DATA_W-1:0]   next_mem_data_out;
  logic                next_mem_data_oe;
  logic [NUM_DEV-1:0]  sel;
  logic [NUM_DEV-1:0]  next_sel;

  // Read wait covers both delays plus two synchroniser stages
  localparam logic [CNT_W-1:0] RD_CYC  = CNT_W'(ACC_CYC + OE_CYC + 2);
  localparam logic [CNT_W-1:0] SU_CYC  = CNT_W'(SETUP_CYC);
  localparam logic [CNT_W-1:0] HD_CYC  = CNT_W'(HOLD_CYC);
  localparam logic [CNT_W-1:0] FL_CYC  = CNT_W'(FLOAT_CYC);
  localparam logic [CNT_W-1:0] PW_CYC  = CNT_W'(PULSE_LEN);
  localparam logic [CNT_W-1:0] ONE     = CNT_W'(1);

  always_comb
  begin
    next_state        = state;
    next_cnt          = cnt;
    next_req_ready    = 1'b0;
    next_rsp_valid    = 1'b0;
    next_rsp_rdata    = rsp_rdata;
    next_mem_addr     = mem_addr;
    next_mem_ce       = mem_ce;
    next_mem_oe_n     = mem_oe_n;
    next_mem_vpp_high = mem_vpp_high;
    next_mem_data_out = mem_data_out;
    next_mem_data_oe  = mem_data_oe;
    next_sel          = sel;
    case (state)
      UVP_IDLE:
      begin
        next_req_ready = 1'b1;
        // Supply rises only once every enable is low, so it never meets a static high enable
        if (req_pgm_mode)
        begin
          next_mem_ce = '0;
        end
        // Supply level follows the mode request only between accesses
        next_mem_vpp_high = req_pgm_mode && (mem_ce == '0);
        if (req_valid && req_ready && (req_pgm_mode == mem_vpp_high))
        begin
          next_req_ready = 1'b0;
          next_sel       = req_dev_sel;
          next_mem_addr  = req_addr;
          next_cnt       = SU_CYC;
          if (req_write && mem_vpp_high)
          begin
            next_mem_oe_n     = '1;
            next_mem_ce       = '0;
            next_mem_data_out = req_wdata;
            next_mem_data_oe  = 1'b1;
            next_state        = UVP_PG_SETUP;
          end
          else
          begin
            // Standby only off the high supply; in program mode ce stays low
            next_mem_ce   = mem_vpp_high ? '0 : ~req_dev_sel;
            next_mem_oe_n = ~req_dev_sel;
            next_cnt      = RD_CYC;
            next_state    = UVP_RD_WAIT;
          end
        end
      end
      UVP_RD_WAIT:
      begin
        next_cnt = cnt - ONE;
        if (cnt == ONE)
        begin
          next_rsp_rdata = din_sync;
          next_rsp_valid = 1'b1;
          next_mem_oe_n  = '1;
          next_cnt       = FL_CYC;
          next_state     = UVP_FLOAT;
        end
      end
      UVP_PG_SETUP:
      begin
        next_cnt = cnt - ONE;
        if (cnt == ONE)
        begin
          next_mem_ce = sel;
          next_cnt    = PW_CYC;
          next_state  = UVP_PG_PULSE;
        end
      end
      UVP_PG_PULSE:
      begin
        // Counted pulse, never a static level
        next_cnt = cnt - ONE;
        if (cnt == ONE)
        begin
          next_mem_ce = '0;
          next_cnt    = HD_CYC;
          next_state  = UVP_PG_HOLD;
        end
      end
      UVP_PG_HOLD:
      begin
        // Address and data still held after enable has fallen
        next_cnt = cnt - ONE;
        if (cnt == ONE)
        begin
          next_mem_data_oe = 1'b0;
          next_rsp_valid   = 1'b1;
          next_state       = UVP_FLOAT;
          next_cnt         = FL_CYC;
        end
      end
      UVP_FLOAT:
      begin
        // Lets the device release the shared bus before the next access
        next_cnt = cnt - ONE;
        if (cnt == ONE)
        begin
          next_mem_ce = mem_vpp_high ? '0 : '1;
          next_state  = UVP_IDLE;
        end
      end
      default:
      begin
        next_state = UVP_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      state        <= UVP_IDLE;
      cnt          <= '0;
      req_ready    <= 1'b0;
      rsp_valid    <= 1'b0;
      rsp_rdata    <= '0;
      mem_addr     <= '0;
      mem_ce       <= '1;
      mem_oe_n     <= '1;
      mem_vpp_high <= 1'b0;
      mem_data_out <= '0;
      mem_data_oe  <= 1'b0;
      sel          <= '0;
    end
    else
    begin
      state        <= next_state;
      cnt          <= next_cnt;
      req_ready    <= next_req_ready;
      rsp_valid    <= next_rsp_valid;
      rsp_rdata    <= next_rsp_rdata;
      mem_addr     <= next_mem_addr;
      mem_ce       <= next_mem_ce;
      mem_oe_n     <= next_mem_oe_n;
      mem_vpp_high <= next_mem_vpp_high;
      mem_data_out <= next_mem_data_out;
      mem_data_oe  <= next_mem_data_oe;
      sel          <= next_sel;
    end
  end
endmodule : uvp_host

// [verification/uvp_host_sva.sv]
`timescale 1ns/1ns
module uvp_host_sva
  import uvp_pkg::*;
#(
  parameter int unsigned NUM_DEV   = 1,
  parameter int unsigned PULSE_LEN = 20
)
(
  input wire logic                       core_clk,
  input wire logic                       sys_rst,
  input wire logic                       req_valid,
  input wire logic                       req_write,
  input wire logic                       req_pgm_mode,
  input wire logic [NUM_DEV-1:0]         req_dev_sel,
  input wire logic                       req_ready,
  input wire logic                       rsp_valid,
  input wire logic [uvp_pkg::ADDR_W-1:0] mem_addr,
  input wire logic [NUM_DEV-1:0]         mem_ce,
  input wire logic [NUM_DEV-1:0]         mem_oe_n,
  input wire logic                       mem_vpp_high,
  input wire logic [uvp_pkg::DATA_W-1:0] mem_data_out,
  input wire logic                       mem_data_oe
);
  logic [NUM_DEV-1:0] sel;
  int unsigned        cnt;
  wire take  = req_valid && req_ready && (req_pgm_mode == mem_vpp_high);
  wire pulse = |mem_ce && mem_data_oe;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // Pulse length counter; reset clears it so an aborted pulse is not judged
  always_ff @(posedge core_clk)
  begin
    cnt <= (sys_rst || !pulse) ? 0 : cnt + 1;
    if (take && req_write) sel <= req_dev_sel;
  end
  sequence s_pulse_end; $fell(|mem_ce) && mem_data_oe; endsequence
  sequence s_read_take; take && !req_write; endsequence
  a_one_gate: assert property ($onehot0(~mem_oe_n))
    else $error("more than one output gate low");
  a_gate_high_pgm: assert property (mem_data_oe |-> &mem_oe_n)
    else $error("output gate low while driving data");
  a_data_pgm_only: assert property (mem_data_oe |-> mem_vpp_high)
    else $error("data driven without high supply");
  a_pulse_len: assert property (s_pulse_end |-> cnt == PULSE_LEN)
    else $error("program pulse length wrong");
  a_no_static_ce: assert property (cnt <= PULSE_LEN)
    else $error("chip enable held high too long");
  a_vpp_ce_low: assert property (mem_vpp_high && !mem_data_oe |-> mem_ce == '0)
    else $error("chip enable high on raised supply outside a write");
  a_pulse_stable: assert property (pulse && $past(pulse) |->
    $stable(mem_addr) && $stable(mem_data_out))
    else $error("address or data moved in pulse");
  a_inhibit_sel: assert property (pulse |-> mem_ce == sel)
    else $error("pulse on unselected device");
  a_read_answer: assert property (s_read_take |-> ##[18:19] rsp_valid)
    else $error("read answer late");
endmodule : uvp_host_sva

// [verification/uvp_eprom_model.sv]
`timescale 1ns/1ns
module uvp_eprom_model
(
  input wire logic        clk,
  input wire logic [10:0] addr,
  input wire logic        ce,
  input wire logic        oe_n,
  input wire logic        vpp,
  input wire logic [7:0]  din,
  output logic     [7:0]  dq,
  output logic            en
);
  logic [7:0]  mem [0:2047];
  logic [10:0] pa;
  logic        armed;
  int          c = 0;
  initial foreach (mem[i]) mem[i] = 8'hFF;
  always @(posedge ce) armed = vpp && oe_n;
  // Bits only clear; a pulse cut short by dropping the supply writes nothing
  always @(negedge ce)
    if (armed === 1'h1 && vpp && oe_n) mem[addr] = mem[addr] & din;
  always @(posedge clk)
  begin
    c <= (ce || oe_n || addr != pa) ? 0 : (c < 15 ? c + 1 : c);
    pa <= addr;
  end
  assign en = !ce && !oe_n;
  // Garbage until access time has run so early sampling shows up
  assign dq = (c >= uvp_pkg::ACC_CYC) ? mem[addr] : ~mem[addr];
endmodule : uvp_eprom_model

// [verification/uvp_host_bench.sv]
`timescale 1ns/1ns
`define CHK(nm, e, s) begin cmp_count++; if ((s) !== (e)) begin n_mismatch++; \
  $display("Error %s exp %h got %h", nm, e, s); end end
module uvp_host_bench;
  import uvp_pkg::*;
  typedef struct packed {logic p; logic w; logic [1:0] sel; logic [10:0] a;
                         logic [7:0] d; logic [7:0] x;} uvp_row_s;
  logic core_clk = 0, sys_rst = 1, req_valid = 0, req_write = 0, req_pgm_mode = 0;
  logic req_ready, rsp_valid, mem_vpp_high, mem_data_oe;
  logic [1:0]  req_dev_sel = 0, mem_ce, mem_oe_n, en;
  logic [10:0] req_addr = 0, mem_addr;
  logic [7:0]  req_wdata = 0, rsp_rdata, mem_data_out, mem_data_in, q0, q1, last = 0, got;
  int          n_mismatch = 0, cmp_count = 0;
  uvp_row_s rows [8] = '{'{0, 0, 1, 0, 0, 8'hFF}, '{1, 1, 3, 11'h7FF, 8'hA5, 0},
    '{1, 0, 1, 11'h7FF, 0, 8'hA5}, '{1, 1, 2, 11'h7FF, 8'h0F, 0}, '{1, 0, 2, 11'h7FF, 0, 8'h05},
    '{0, 0, 1, 11'h7FF, 0, 8'hA5}, '{0, 0, 2, 11'h7FF, 0, 8'h05}, '{0, 0, 2, 1, 0, 8'hFF}};
  always #20 core_clk = ~core_clk;
  // Undriven bus shows the inverse of its last value, never a stale match
  always @(posedge core_clk) last <= mem_data_in;
  assign mem_data_in = en[0] ? q0 : en[1] ? q1 : mem_data_oe ? mem_data_out : ~last;
  uvp_host #(.NUM_DEV(2), .PULSE_LEN(20)) uvp_host_inst (.core_clk(core_clk), .sys_rst(sys_rst),
    .req_valid(req_valid), .req_write(req_write), .req_pgm_mode(req_pgm_mode),
    .req_dev_sel(req_dev_sel), .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .mem_addr(mem_addr), .mem_ce(mem_ce),
    .mem_oe_n(mem_oe_n), .mem_vpp_high(mem_vpp_high), .mem_data_out(mem_data_out),
    .mem_data_oe(mem_data_oe), .mem_data_in(mem_data_in));
  uvp_eprom_model uvp_eprom_model_inst0 (.clk(core_clk), .addr(mem_addr), .ce(mem_ce[0]),
    .oe_n(mem_oe_n[0]), .vpp(mem_vpp_high), .din(mem_data_in), .dq(q0), .en(en[0]));
  uvp_eprom_model uvp_eprom_model_inst1 (.clk(core_clk), .addr(mem_addr), .ce(mem_ce[1]),
    .oe_n(mem_oe_n[1]), .vpp(mem_vpp_high), .din(mem_data_in), .dq(q1), .en(en[1]));
  task automatic xfer(input uvp_row_s r);
    int n;
    n = 0;
    @(posedge core_clk);
    {req_valid, req_write, req_pgm_mode, req_dev_sel} <= {1'h1, r.w, r.p, r.sel};
    {req_addr, req_wdata} <= {r.a, r.d};
    do @(negedge core_clk); while (!(req_ready === 1'h1 && mem_vpp_high === r.p) && ++n < 500);
    @(posedge core_clk);
    req_valid <= 1'h0;
    do @(negedge core_clk); while (rsp_valid !== 1'h1 && ++n < 1000);
    got = rsp_rdata;
    `CHK("answer", 1'h1, rsp_valid)
  endtask : xfer
  task automatic report_and_stop;
    $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : report_and_stop
  initial
  begin
    repeat (5000) @(posedge core_clk);
    n_mismatch++;
    report_and_stop();
  end
  initial
  begin
    @(negedge core_clk);
    `CHK("reset enables", 4'hF, {mem_ce, mem_oe_n})
    `CHK("reset flags", 4'h0, {mem_vpp_high, mem_data_oe, req_ready, rsp_valid})
    @(posedge core_clk);
    sys_rst <= 1'h0;
    foreach (rows[i])
    begin
      xfer(rows[i]);
      if (!rows[i].w) `CHK("read data", rows[i].x, got)
    end
    // Reset in mid-pulse must leave the location unwritten
    @(posedge core_clk);
    {req_valid, req_write, req_pgm_mode, req_dev_sel} <= 5'h1D;
    {req_addr, req_wdata} <= {11'h123, 8'h00};
    repeat (62) @(negedge core_clk);
    `CHK("in pulse", 2'h1, mem_ce)
    @(posedge core_clk);
    sys_rst <= 1'h1;
    req_valid <= 1'h0;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'h0;
    @(negedge core_clk);
    `CHK("abort pins", 3'h6, {mem_ce, mem_vpp_high})
    xfer('{1'h0, 1'h0, 2'h1, 11'h123, 8'h00, 8'hFF});
    `CHK("aborted loc", 8'hFF, got)
    report_and_stop();
  end
endmodule : uvp_host_bench
bind uvp_host uvp_host_sva #(.NUM_DEV(NUM_DEV), .PULSE_LEN(PULSE_LEN)) uvp_host_sva_inst (
  .core_clk(core_clk), .sys_rst(sys_rst), .req_valid(req_valid), .req_write(req_write),
  .req_pgm_mode(req_pgm_mode), .req_dev_sel(req_dev_sel), .req_ready(req_ready),
  .rsp_valid(rsp_valid), .mem_addr(mem_addr), .mem_ce(mem_ce), .mem_oe_n(mem_oe_n),
  .mem_vpp_high(mem_vpp_high), .mem_data_out(mem_data_out), .mem_data_oe(mem_data_oe));
